// *** rtl/apc_top.sv ***
// module: audio pulse-width modulator with sample fifo and register port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module apc_top #(
  parameter int DEPTH = apc_pkg::FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic src_slow_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic modulator_output_pin_o,
  output logic irq_o
);
  localparam int PW = $clog2(DEPTH + 1);
  localparam int IW = $clog2(DEPTH);

  //=========================================================
  // state
  typedef struct packed {
    logic [2:0] slow_sync;
    logic src;
    logic [6:0] prescale;
    logic irqen;
    logic en;
    logic [1:0] rep;
    logic [1:0] tap;
    logic [7:0] period;
    logic [7:0] count;
    logic [6:0] pre_cnt;
    logic [3:0] chain;
    logic [2:0] rep_cnt;
    logic [7:0] sample;
    logic [DEPTH-1:0][7:0] mem;
    logic [IW-1:0] rd_ptr;
    logic [IW-1:0] wr_ptr;
    logic [PW-1:0] fill;
    logic [apc_pkg::STAT_BITS-1:0] stat;
    logic [apc_pkg::STAT_BITS-1:0] mask;
    logic [15:0] rdata;
    logic pin;
    logic irq;
  } apc_state_t;

  apc_state_t s_q;
  apc_state_t s_d;

  function automatic logic [IW-1:0] ptr_inc(input logic [IW-1:0] p);
    ptr_inc = (p == IW'(DEPTH - 1)) ? '0 : p + IW'(1);
  endfunction : ptr_inc

  // chain stage that feeds the counter; a constant select keeps the decode legal
  function automatic logic tap_hit(input logic [3:0] c, input logic [1:0] t);
    unique case (t)
      2'h0: tap_hit = c[0];
      2'h1: tap_hit = &c[1:0];
      2'h2: tap_hit = &c[2:0];
      2'h3: tap_hit = &c;
    endcase
  endfunction : tap_hit

  logic [7:0] per_eff;
  logic room;
  logic slow_edge;
  logic src_tick;
  logic tap_tick;
  logic wrap;
  logic [15:0] ctl_view;

  always_comb begin
    room = s_q.fill < PW'(DEPTH);
    slow_edge = s_q.slow_sync[1] & ~s_q.slow_sync[2];
    src_tick = s_q.src ? slow_edge : 1'b1;
    tap_tick = src_tick && (s_q.pre_cnt == s_q.prescale) && tap_hit(s_q.chain, s_q.tap);
    // all-ones period behaves as the reset period, else the count could never match
    per_eff = (s_q.period == '1) ? apc_pkg::PERIOD_RESET : s_q.period;
    wrap = tap_tick && ({1'b0, s_q.count} >= {1'b0, per_eff} + 9'h001);
    ctl_view = '0;
    ctl_view[apc_pkg::CTL_SRC] = s_q.src;
    ctl_view[apc_pkg::CTL_PRE_HI:apc_pkg::CTL_PRE_LO] = s_q.prescale;
    ctl_view[apc_pkg::CTL_IRQ] = s_q.stat[apc_pkg::STAT_REQ];
    ctl_view[apc_pkg::CTL_IRQEN] = s_q.irqen;
    ctl_view[apc_pkg::CTL_ROOM] = room;
    ctl_view[apc_pkg::CTL_EN] = s_q.en;
    ctl_view[apc_pkg::CTL_TAP_HI:apc_pkg::CTL_TAP_LO] = s_q.tap;
  end

  always_comb begin
    s_d = s_q;
    s_d.slow_sync = {s_q.slow_sync[1:0], src_slow_i};
    s_d.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        apc_pkg::ADDR_CONTROL: s_d.rdata = ctl_view;
        apc_pkg::ADDR_SAMPLE: s_d.rdata = {8'h00, s_q.sample};
        apc_pkg::ADDR_PERIOD: s_d.rdata = {8'h00, s_q.period};
        apc_pkg::ADDR_COUNT: s_d.rdata = {8'h00, s_q.count};
        apc_pkg::ADDR_STATUS: s_d.rdata = {{(16 - apc_pkg::STAT_BITS){1'b0}}, s_q.stat};
        apc_pkg::ADDR_MASK: s_d.rdata = {{(16 - apc_pkg::STAT_BITS){1'b0}}, s_q.mask};
        default: s_d.rdata = '0;
      endcase
    end
    if (rd_i && addr_i == apc_pkg::ADDR_CONTROL) begin
      s_d.stat[apc_pkg::STAT_REQ] = 1'b0;
    end
    if (wr_i && addr_i == apc_pkg::ADDR_STATUS) begin
      s_d.stat = s_q.stat & ~wdata_i[apc_pkg::STAT_BITS-1:0];
    end
    if (wr_i && addr_i == apc_pkg::ADDR_CONTROL) begin
      s_d.en = wdata_i[apc_pkg::CTL_EN];
      if (s_q.en) begin
        s_d.src = wdata_i[apc_pkg::CTL_SRC];
        s_d.prescale = wdata_i[apc_pkg::CTL_PRE_HI:apc_pkg::CTL_PRE_LO];
        s_d.irqen = wdata_i[apc_pkg::CTL_IRQEN];
        s_d.rep = wdata_i[apc_pkg::CTL_REP_HI:apc_pkg::CTL_REP_LO];
        s_d.tap = wdata_i[apc_pkg::CTL_TAP_HI:apc_pkg::CTL_TAP_LO];
        if (wdata_i[apc_pkg::CTL_IRQ]) begin
          s_d.stat[apc_pkg::STAT_REQ] = 1'b1;
        end
      end
    end
    if (wr_i && s_q.en) begin
      unique case (addr_i)
        apc_pkg::ADDR_PERIOD: s_d.period = wdata_i[7:0];
        apc_pkg::ADDR_MASK: s_d.mask = wdata_i[apc_pkg::STAT_BITS-1:0];
        default: s_d.mask = s_q.mask;
      endcase
    end
    // the disabling write itself already forces the pin low and flushes
    if (!s_q.en || !s_d.en) begin
      s_d.pre_cnt = '0;
      s_d.chain = '0;
      s_d.count = '0;
      s_d.rep_cnt = '0;
      s_d.fill = '0;
      s_d.rd_ptr = '0;
      s_d.wr_ptr = '0;
      s_d.pin = 1'b0;
      if (s_d.en) begin
        s_d.pin = 1'b1;
        s_d.stat[apc_pkg::STAT_REQ] = 1'b1;
        s_d.stat[apc_pkg::STAT_EMPTY] = 1'b1;
      end
    end else begin
      if (src_tick) begin
        s_d.pre_cnt = (s_q.pre_cnt == s_q.prescale) ? '0 : s_q.pre_cnt + 7'h01;
        if (s_q.pre_cnt == s_q.prescale) begin
          s_d.chain = s_q.chain + 4'h1;
        end
      end
      if (tap_tick) begin
        s_d.count = wrap ? 8'h00 : s_q.count + 8'h01;
        if (wrap) begin
          s_d.pin = 1'b1;
        end else if (s_q.count + 8'h01 >= s_q.sample) begin
          s_d.pin = 1'b0;
        end
      end
      if (wrap) begin
        s_d.rep_cnt = s_q.rep_cnt + 3'h1;
        if (s_q.rep_cnt == 3'((1 << s_q.rep) - 1)) begin
          s_d.rep_cnt = '0;
          if (s_q.fill != '0) begin
            s_d.sample = s_q.mem[s_q.rd_ptr];
            s_d.rd_ptr = ptr_inc(s_q.rd_ptr);
            s_d.fill = s_q.fill - PW'(1);
          end
        end
      end
      if (wr_i && addr_i == apc_pkg::ADDR_SAMPLE && room) begin
        s_d.mem[s_q.wr_ptr] = wdata_i[7:0];
        s_d.wr_ptr = ptr_inc(s_q.wr_ptr);
        s_d.fill = s_d.fill + PW'(1);
      end
      // request at one or zero bytes
      if (s_d.fill <= PW'(1) && s_q.fill > PW'(1)) begin
        s_d.stat[apc_pkg::STAT_REQ] = 1'b1;
      end
      if (s_d.fill == '0 && s_q.fill != '0) begin
        s_d.stat[apc_pkg::STAT_EMPTY] = 1'b1;
      end
    end
    s_d.irq = |(s_d.stat & s_d.mask) | (s_q.irqen & s_d.stat[apc_pkg::STAT_REQ]);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.period <= apc_pkg::PERIOD_RESET;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign modulator_output_pin_o = s_q.pin;
  assign irq_o = s_q.irq;
endmodule : apc_top
`default_nettype wire

// *** rtl/apc_pkg.sv ***
// package: register map, field layout and constants of the audio pulse-width modulator
//=========================================================
// Notes on behaviour
// - room flag high while fifo can take a byte
// - sample writes dropped while room flag clear
// - other registers except status and the control enable bit ignore writes while disabled
// - disabled: pin low, counters held at zero, fifo flushed
// - enabling starts a period with pin high
// - enabling sets the interrupt request bit
// - repeat code plays sample 1,2,4,8 times
// - prescaler divides source by value plus one
// - counter restarts at period plus one
// - request sets at <=1 byte, clears on control read
// - sample fifo holds five bytes
package apc_pkg;
  //=========================================================
  // register offsets (word addresses)
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_SAMPLE = 3'h1;
  localparam logic [2:0] ADDR_PERIOD = 3'h2;
  localparam logic [2:0] ADDR_COUNT = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_MASK = 3'h5;
  //=========================================================
  // control field positions
  localparam int CTL_SRC = 15;
  localparam int CTL_PRE_HI = 14;
  localparam int CTL_PRE_LO = 8;
  localparam int CTL_IRQ = 7;
  localparam int CTL_IRQEN = 6;
  localparam int CTL_ROOM = 5;
  localparam int CTL_EN = 4;
  localparam int CTL_REP_HI = 3;
  localparam int CTL_REP_LO = 2;
  localparam int CTL_TAP_HI = 1;
  localparam int CTL_TAP_LO = 0;
  //=========================================================
  // reset values and sizes
  localparam logic [7:0] PERIOD_RESET = 8'hFE;
  localparam int FIFO_DEPTH = 5;
  localparam int STAT_BITS = 2;
  localparam int STAT_REQ = 0;
  localparam int STAT_EMPTY = 1;
endpackage : apc_pkg

// *** bench/apc_chk.sv ***
// checker: port assertions of the modulator
`timescale 1ns/1ps
`default_nettype none
module apc_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic src_slow_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic modulator_output_pin_o,
  input wire logic irq_o
);
  //======
  // enable bit as last written
  logic en_q;
  logic wc;
  logic rc;
  assign wc = wr_i && addr_i == 3'h0;
  assign rc = rd_i && addr_i == 3'h0;
  always_ff @(posedge clock_i) en_q <= rst_i ? 1'b0 : (wc && ce_i) ? wdata_i[4] : en_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_enable_pin: assert property (wc && wdata_i[4] && !en_q |=> modulator_output_pin_o)
    else $error("pin low on enable");
  a_idle_pin: assert property (!en_q |-> !modulator_output_pin_o)
    else $error("pin high when off");
  a_idle_ctl: assert property (rc && !en_q |=> rdata_o[5:2] == 4'h8)
    else $error("idle control read");
  a_run_rep: assert property (rc && en_q |=> rdata_o[4:2] == 3'h4)
    else $error("run control read");
  a_idle_count: assert property (rd_i && addr_i == 3'h3 && !en_q |=> rdata_o == 16'h0000)
    else $error("count not frozen");
  a_enable_req: assert property (wc && wdata_i[4] && !en_q ##2 rc |=> rdata_o[7])
    else $error("no request on enable");
  a_period_kept: assert property ((rd_i && addr_i == 3'h2 && !en_q) ##2 (wr_i && addr_i == 3'h2)
    ##2 (rd_i && addr_i == 3'h2) |=> rdata_o == $past(rdata_o, 4)) else $error("period changed");
  a_tap_back: assert property (wc && en_q ##2 rc |=> rdata_o[1:0] == $past(wdata_i[1:0], 3))
    else $error("tap readback");
endmodule : apc_chk
bind apc_top apc_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .src_slow_i(src_slow_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .modulator_output_pin_o(modulator_output_pin_o), .irq_o(irq_o));
`default_nettype wire

// *** bench/apc_lpf.sv ***
// partner model: rc low-pass filter on the modulator pin
`timescale 1ns/1ps
`default_nettype none
module apc_lpf (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic [7:0] level_o
);
  //======
  // moves an eighth of the way to the pin each cycle; coarse but shows duty
  logic [10:0] acc_q;
  always_ff @(posedge clock_i) acc_q <= rst_i ? 11'h000 : acc_q - (acc_q >> 3) + (pin_i ? 11'h0FF : 11'h000);
  assign level_o = acc_q[10:3];
endmodule : apc_lpf
`default_nettype wire

// *** bench/apc_top_tb.sv ***
// testbench: register-level tests of the modulator
`timescale 1ns/1ps
`default_nettype none
module apc_top_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic [15:0] v;
  logic pin;
  logic irq;
  logic [7:0] level;
  int failures = 0;
  int num_checks = 0;
  always #50 clock_i = ~clock_i;
  apc_top dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .src_slow_i(1'b0), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .modulator_output_pin_o(pin), .irq_o(irq));
  apc_lpf lpf (.clock_i(clock_i), .rst_i(rst_i), .pin_i(pin), .level_o(level));
  //======
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // idle cycle before each strobe keeps one assignment per step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    check(v & m, exp);
  endtask : rd
  //======
  // main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(3'h3, 16'hFFFF, 16'h0000);
    rd(3'h0, 16'hFFFF, 16'h0020);
    rd(3'h2, 16'hFFFF, 16'h00FE);
    wr(3'h2, 16'h0003);
    rd(3'h2, 16'hFFFF, 16'h00FE);
    wr(3'h0, 16'h0010);
    #1 check(16'(pin), 16'h0001);
    rd(3'h0, 16'hFFFF, 16'h00B0);
    wr(3'h5, 16'h0003);
    repeat (2) @(posedge clock_i);
    #1 check(16'(irq), 16'h0001);
    wr(3'h5, 16'h0000);
    repeat (2) @(posedge clock_i);
    #1 check(16'(irq), 16'h0000);
    wr(3'h0, 16'h0013);
    rd(3'h0, 16'hFF7F, 16'h0033);
    repeat (4) wr(3'h1, 16'h0003);
    wr(3'h1, 16'h0002);
    rd(3'h0, 16'h0020, 16'h0000);
    wr(3'h1, 16'h0007);
    wr(3'h4, 16'h0003);
    wr(3'h5, 16'h0003);
    repeat (2) @(posedge clock_i);
    #1 check(16'(irq), 16'h0000);
    for (int i = 0; i < 3000 && v[5] !== 1'b1; i++) rd(3'h0, 16'h0000, 16'h0000);
    check(v & 16'h0020, 16'h0020);
    if (v[5] !== 1'b1) final_report;
    wr(3'h2, 16'h0003);
    wr(3'h0, 16'h001C);
    rd(3'h0, 16'h003F, 16'h0030);
    repeat (400) @(posedge clock_i);
    #1 check(16'(level > 8'h10 && level < 8'hF0), 16'h0001);
    rd(3'h1, 16'hFFFF, 16'h0002);
    wr(3'h0, 16'h0000);
    #1 check(16'(pin), 16'h0000);
    rd(3'h0, 16'h003C, 16'h0020);
    rd(3'h3, 16'hFFFF, 16'h0000);
    final_report;
  end
endmodule : apc_top_tb
`default_nettype wire
